/* File: ecl_apb_slave.sv */
/*
 * APB slave: no wait state, registered ready, read data and error.
 * Assumes the register file decodes rb.addr into rb.hit and rb.rdata.
 */
`timescale 1ns/100ps
module ecl_apb_slave #(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    ecl_reg_if.bus rb
);
    // ==========================================================
    // Setup phase detection and write strobe
    wire setup = psel & ~penable & ~pready;

    assign rb.addr = paddr;
    assign rb.wdata = pwdata;
    assign rb.wr_en = ce & psel & penable & pready & pwrite & ~pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'h0;
            prdata <= 32'h0;
            pslverr <= 1'h0;
        end else if (ce) begin
            pready <= setup;
            prdata <= (setup & ~pwrite & rb.hit) ? rb.rdata : 32'h0;
            pslverr <= setup & ~rb.hit;
        end
    end
endmodule

/* File: ecl_error_log.sv */
/*
 * Error-log control for the error-checking memory: control/status word,
 * check-bit capture and injection, failed-address logging and readback,
 * block protection, interrupt status and mask, APB register access.
 * Assumes the memory controller presents one cycle request per pulse of
 * cyc_req with its stored check bits, syndrome and error flags.
 */
`timescale 1ns/100ps

// Behaviour
// - Diagnostic read copies stored check bits
// - Diagnostic write stores field as check bits
// - Field shows check bits when diagnostic set and high select clear
// - Protect disabled: modes cover whole memory
// - Protect enabled: selected block keeps normal checking
// - Low select shows failed address 11-17
// - High select shows address 18-21 and 1
// - High select blocks software check-bit loads
// - Uncorrectable flag set by hardware or software
// - Control bits decode seven operating modes
// - Both bits clear selects normal checking
// - Block select zero lower, one upper
// - Diagnostic bit selects diagnostic data cycles
module ecl_error_log #(
    parameter int PADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic bus_init,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic cyc_req,
    input wire logic cyc_write,
    input wire logic [ecl_pkg::MEM_A_MSB:1] cyc_addr,
    input wire logic [ecl_pkg::CHK_W-1:0] cyc_check_rd,
    input wire logic [ecl_pkg::CHK_W-1:0] cyc_syndrome,
    input wire logic cyc_err_single,
    input wire logic cyc_err_multi,
    output logic cyc_done,
    output logic cyc_check_force,
    output logic [ecl_pkg::CHK_W-1:0] cyc_check_wr,
    output logic cyc_correct_dis,
    output logic cyc_uncorrectable
);
    // ==========================================================
    // Elaboration checks
    generate
        if (PADDR_W < 4 || PADDR_W > 32) begin : g_bad_aw
            $error("PADDR_W must lie between 4 and 32");
        end
    endgenerate

    // ==========================================================
    // State
    logic [ecl_pkg::CSR_W-1:0] ctl;
    logic [ecl_pkg::CHK_W-1:0] diag_chk;
    logic [ecl_pkg::LO_W-1:0] log_lo;
    logic [ecl_pkg::HI_W-1:0] log_hi;
    logic [ecl_pkg::CHK_W-1:0] log_syn;
    logic [ecl_pkg::IRQ_W-1:0] ist;
    logic [ecl_pkg::IRQ_W-1:0] imask;
    ecl_pkg::ecl_mode_t last_mode;

    // ==========================================================
    // APB slave
    ecl_reg_if #(.AW(PADDR_W)) rb ();

    ecl_apb_slave #(.AW(PADDR_W)) u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .rb(rb)
    );

    // ==========================================================
    // Control bits and mode decode
    wire dis = ctl[ecl_pkg::B_DIS];
    wire diag = ctl[ecl_pkg::B_DIAG];
    wire bsel = ctl[ecl_pkg::B_BSEL];
    wire pen = ctl[ecl_pkg::B_PEN];
    wire hsel = ctl[ecl_pkg::B_HSEL];
    wire unc_flag = ctl[ecl_pkg::B_UNC];
    wire in_prot;
    wire eff_diag;
    wire eff_dis;
    ecl_pkg::ecl_mode_t mode;

    ecl_mode_decode u_mode (
        .dis(dis),
        .diag(diag),
        .pen(pen),
        .bsel(bsel),
        .addr(cyc_addr),
        .mode(mode),
        .in_prot(in_prot),
        .eff_diag(eff_diag),
        .eff_dis(eff_dis)
    );

    // ==========================================================
    // Memory cycle events
    wire rd_cyc = cyc_req & ~cyc_write;
    wire wr_cyc = cyc_req & cyc_write;
    wire rd_unc = eff_dis ? (cyc_err_single | cyc_err_multi) : cyc_err_multi;
    wire unc_ev = rd_cyc & rd_unc;
    // Single errors in a protected block stay silent while correction is off
    wire single_ev = rd_cyc & cyc_err_single & ~(dis & in_prot);
    // Double errors override; singles overwrite a logged double only while eff_dis is set
    wire log_ev = unc_ev | (single_ev & ~unc_flag);
    wire diag_rd = rd_cyc & eff_diag;
    wire diag_wr = wr_cyc & eff_diag;

    // ==========================================================
    // Register write decode
    wire sw_csr_wr = rb.wr_en && (rb.addr == PADDR_W'(ecl_pkg::OFF_CSR));
    wire sw_stat_wr = rb.wr_en && (rb.addr == PADDR_W'(ecl_pkg::OFF_IRQ_STAT));
    wire sw_mask_wr = rb.wr_en && (rb.addr == PADDR_W'(ecl_pkg::OFF_IRQ_MASK));
    wire [ecl_pkg::CSR_W-1:0] wdata16 = rb.wdata[ecl_pkg::CSR_W-1:0];

    wire [ecl_pkg::CSR_W-1:0] ctl_sw = sw_csr_wr ? (wdata16 & ecl_pkg::CTL_MASK) : ctl;
    wire [ecl_pkg::CSR_W-1:0] ctl_base = bus_init ? ecl_pkg::CSR_RESET : ctl_sw;
    wire [ecl_pkg::CSR_W-1:0] hw_set = (ecl_pkg::CSR_W'(unc_ev) << ecl_pkg::B_UNC)
                                     | (ecl_pkg::CSR_W'(single_ev) << ecl_pkg::B_SINGLE);
    wire [ecl_pkg::CSR_W-1:0] next_ctl = ctl_base | hw_set;

    wire sw_chk_load = sw_csr_wr & ~hsel;
    wire [ecl_pkg::CHK_W-1:0] next_diag_chk = diag_rd ? cyc_check_rd
        : sw_chk_load ? wdata16[ecl_pkg::B_CHK_HI:ecl_pkg::B_MF_LO] : diag_chk;

    // ==========================================================
    // Register read view
    // low address half
    wire [ecl_pkg::LO_W-1:0] mf_view = !diag ? (hsel ? {2'h0, log_hi} : log_lo)
                                     : (hsel ? {1'h0, log_syn} : {1'h0, diag_chk});
    wire [ecl_pkg::CSR_W-1:0] csr_view = {ctl[ecl_pkg::B_UNC:ecl_pkg::B_PEN], 1'h0, mf_view,
                                          ctl[ecl_pkg::B_SINGLE:ecl_pkg::B_DIS], 1'h0};

    wire hit_csr = (rb.addr == PADDR_W'(ecl_pkg::OFF_CSR));
    wire hit_stat = (rb.addr == PADDR_W'(ecl_pkg::OFF_IRQ_STAT));
    wire hit_mask = (rb.addr == PADDR_W'(ecl_pkg::OFF_IRQ_MASK));
    wire hit_mode = (rb.addr == PADDR_W'(ecl_pkg::OFF_MODE));

    assign rb.hit = hit_csr | hit_stat | hit_mask | hit_mode;
    assign rb.rdata = hit_csr ? {16'h0, csr_view}
                    : hit_stat ? {30'h0, ist}
                    : hit_mask ? {30'h0, imask}
                    : hit_mode ? {29'h0, last_mode}
                    : 32'h0;

    // ==========================================================
    // Control word, check field and log registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= ecl_pkg::CSR_RESET;
            diag_chk <= '0;
        end else if (ce) begin
            ctl <= next_ctl;
            diag_chk <= next_diag_chk;
        end
    end

    // Failed address and syndrome; not touched by bus init
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_lo <= '0;
            log_hi <= '0;
            log_syn <= '0;
        end else if (ce && log_ev) begin
            log_lo <= cyc_addr[17:11];
            log_hi <= {cyc_addr[1], cyc_addr[21:18]};
            log_syn <= cyc_syndrome;
        end
    end

    // ==========================================================
    // Memory cycle answer
    // inject check field on diagnostic writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_done <= 1'h0;
            cyc_check_force <= 1'h0;
            cyc_check_wr <= '0;
            cyc_correct_dis <= 1'h0;
            cyc_uncorrectable <= 1'h0;
            last_mode <= ecl_pkg::ECL_NORM_EN;
        end else if (ce) begin
            cyc_done <= cyc_req;
            cyc_check_force <= diag_wr;
            cyc_check_wr <= diag_chk;
            cyc_correct_dis <= cyc_req & eff_dis;
            cyc_uncorrectable <= unc_ev;
            if (cyc_req) begin
                last_mode <= mode;
            end
        end
    end

    // ==========================================================
    // Interrupt status, mask and output
    wire [ecl_pkg::IRQ_W-1:0] irq_ev = {single_ev, unc_ev};
    wire [ecl_pkg::IRQ_W-1:0] next_ist;

    genvar gi;
    generate
        for (gi = 0; gi < ecl_pkg::IRQ_W; gi++) begin : g_ist
            assign next_ist[gi] = irq_ev[gi] | (ist[gi] & ~(sw_stat_wr & rb.wdata[gi]));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist <= ecl_pkg::IRQ_RESET;
            imask <= ecl_pkg::IRQ_RESET;
            irq <= 1'h0;
        end else if (ce) begin
            ist <= next_ist;
            imask <= sw_mask_wr ? rb.wdata[ecl_pkg::IRQ_W-1:0] : imask;
            irq <= |(next_ist & (sw_mask_wr ? rb.wdata[ecl_pkg::IRQ_W-1:0] : imask));
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_diag_read_copy: assert property (ce && diag_rd |=> diag_chk == $past(cyc_check_rd))
        else $error("diagnostic read did not capture check bits");
    a_diag_write_inj: assert property (ce && diag_wr |=> cyc_check_force && cyc_check_wr == $past(diag_chk))
        else $error("diagnostic write did not inject check field");
    a_check_view: assert property (diag && !hsel |-> csr_view[10:5] == diag_chk)
        else $error("check field not shown in diagnostic view");
    a_no_protect: assert property (!pen |-> eff_diag == diag && eff_dis == dis)
        else $error("mode suppressed with protection off");
    a_block_guard: assert property (pen && cyc_addr[21:16] == '0 && cyc_addr[15] == bsel |-> !eff_diag && !eff_dis)
        else $error("protected block entered a test mode");
    a_low_addr: assert property (ce && log_ev ##1 (!diag && !hsel) |-> csr_view[11:5] == $past(cyc_addr[17:11]))
        else $error("low failed address not presented");
    a_high_addr: assert property (!diag && hsel |-> csr_view[11:5] == {2'h0, log_hi} && csr_view[9] == log_hi[4])
        else $error("high failed address not presented");
    a_hsel_guard: assert property (ce && sw_csr_wr && hsel && !diag_rd |=> $stable(diag_chk))
        else $error("check field loaded with high select set");
    a_unc_set: assert property (ce && unc_ev |=> unc_flag ##1 (unc_flag || $past(sw_csr_wr) || $past(bus_init)))
        else $error("uncorrectable flag not set");
    a_mode_seen: assert property (ce && cyc_req |=> last_mode == $past(mode))
        else $error("cycle mode not recorded");
    a_mode_normal: assert property (!dis && !diag |-> mode == ecl_pkg::ECL_NORM_EN)
        else $error("normal mode not selected");
    a_block_lower: assert property (pen && !bsel && cyc_addr[21:15] == '0 |-> in_prot)
        else $error("lower block not protected");
    a_diag_select: assert property (diag && !in_prot |-> eff_diag)
        else $error("diagnostic bit not applied");
    a_init_clear: assert property (ce && bus_init && !cyc_req |=> ctl == ecl_pkg::CSR_RESET && csr_view[12] == 1'h0)
        else $error("bus init did not clear control bits");
    a_irq_level: assert property (ce |=> irq == |(ist & imask))
        else $error("interrupt output disagrees with status");

    c_diag_read: cover property (ce && diag_rd ##1 cyc_done);
    c_diag_write: cover property (ce && diag_wr ##1 cyc_check_force);
    c_unc_irq: cover property (ce && unc_ev ##[1:4] irq);
    c_protected: cover property (ce && cyc_req && in_prot && diag);
endmodule

/* File: ecl_error_log_tb_top.sv */
/*
 * Self-checking bench of the error-log control block: APB register
 * tasks, memory cycles through the memory-side model, expected values.
 * Assumes the zero-wait-state APB answer and the one-cycle memory answer.
 */
`timescale 1ns/100ps
module ecl_error_log_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic bus_init = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, irq, re;
    logic go = 1'b0, wr = 1'b0, es = 1'b0, em = 1'b0;
    logic [21:1] addr = '0;
    logic busy, got_unc, got_dis, got_force;
    logic [5:0] got_chk;
    logic c_req, c_wr, c_es, c_em, c_done, c_force, c_dis, c_unc;
    logic [21:1] c_addr;
    logic [5:0] c_chk, c_syn, c_chk_wr;
    int errors = 0;
    int checked = 0;
    localparam logic [21:1] DA = 21'h008003;
    localparam logic [21:1] EA = {4'hA, 7'h5B, 9'h000, 1'b1};
    localparam logic [15:0] MCSR [0:6] = '{16'h0000, 16'h0002, 16'h2002, 16'h0004, 16'h0006, 16'h2004, 16'h2006};
    localparam logic [15:0] PCSR [0:4] = '{16'h2006, 16'h2006, 16'h200E, 16'h200E, 16'h0006};
    localparam logic [21:1] PADR [0:4] = '{21'h000003, 21'h004003, 21'h004003, 21'h000003, 21'h000003};
    localparam logic [4:0] PDIS = 5'h1A;

    always #5 pclk = ~pclk;

    ecl_error_log #(.PADDR_W(8)) ecl_error_log_i (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .bus_init(bus_init), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .cyc_req(c_req), .cyc_write(c_wr),
        .cyc_addr(c_addr), .cyc_check_rd(c_chk), .cyc_syndrome(c_syn), .cyc_err_single(c_es),
        .cyc_err_multi(c_em), .cyc_done(c_done), .cyc_check_force(c_force), .cyc_check_wr(c_chk_wr),
        .cyc_correct_dis(c_dis), .cyc_uncorrectable(c_unc));

    ecl_mem_model ecl_mem_model_i (
        .pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr), .es(es), .em(em),
        .busy(busy), .got_unc(got_unc), .got_dis(got_dis), .got_force(got_force), .got_chk(got_chk),
        .cyc_req(c_req), .cyc_write(c_wr), .cyc_addr(c_addr), .cyc_check_rd(c_chk),
        .cyc_syndrome(c_syn), .cyc_err_single(c_es), .cyc_err_multi(c_em), .cyc_done(c_done),
        .cyc_check_force(c_force), .cyc_check_wr(c_chk_wr), .cyc_correct_dis(c_dis),
        .cyc_uncorrectable(c_unc));

    // ==========================================================
    // Report, compare and access tasks
    task automatic print_verdict;
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic hang;
        errors++;
        $display("wrong value at %0t: no answer", $time);
        print_verdict;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang;
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rv, exp);
    endtask

    task automatic cyc(input logic w, input logic [21:1] a, input logic s, input logic m);
        int n;
        n = 0;
        go <= 1'b1;
        wr <= w;
        addr <= a;
        es <= s;
        em <= m;
        @(posedge pclk);
        go <= 1'b0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 20);
        if (n >= 20) hang;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        cmp({31'h0, re}, 32'h1);
        wrr(8'h00, 32'h0004);
        cyc(1'b0, DA, 1'b0, 1'b0);
        rd(8'h00, 32'h0464);
        wrr(8'h00, 32'h02A4);
        cyc(1'b1, DA, 1'b0, 1'b0);
        cmp({25'h0, got_force, got_chk}, {25'h0, 1'b1, 6'h15});
        cyc(1'b0, DA, 1'b0, 1'b0);
        rd(8'h00, 32'h02A4);
        wrr(8'h00, 32'h42A4);
        wrr(8'h00, 32'h4544);
        wrr(8'h00, 32'h0004);
        rd(8'h00, 32'h02A4);
        wrr(8'h00, 32'h0000);
        cyc(1'b1, DA, 1'b0, 1'b0);
        cmp({31'h0, got_force}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wrr(8'h00, {16'h0, MCSR[i]});
            cyc(1'b0, DA, 1'b0, 1'b0);
            rd(8'h0C, 32'(i));
            cmp({31'h0, got_dis}, {31'h0, MCSR[i][1]});
        end
        for (int i = 0; i < 5; i++) begin
            wrr(8'h00, {16'h0, PCSR[i]});
            cyc(1'b0, PADR[i], 1'b0, 1'b0);
            cmp({31'h0, got_dis}, {31'h0, PDIS[i]});
        end
        wrr(8'h00, 32'h0000);
        cyc(1'b0, EA, 1'b0, 1'b1);
        cmp({31'h0, got_unc}, 32'h1);
        rd(8'h00, 32'h8B60);
        wrr(8'h00, 32'hC000);
        rd(8'h00, 32'hC340);
        rd(8'h04, 32'h1);
        cmp({31'h0, irq}, 32'h0);
        wrr(8'h08, 32'h1);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        wrr(8'h04, 32'h1);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        rd(8'h04, 32'h0);
        wrr(8'h00, 32'h0002);
        cyc(1'b0, EA, 1'b1, 1'b0);
        cmp({31'h0, got_unc}, 32'h1);
        rd(8'h00, 32'h8B72);
        rd(8'h04, 32'h3);
        wrr(8'h00, 32'h8000);
        rd(8'h00, 32'h8B60);
        wrr(8'h00, 32'h0000);
        rd(8'h00, 32'h0B60);
        wrr(8'h00, 32'hB00A);
        rd(8'h00, 32'hAB6A);
        bus_init <= 1'b1;
        @(posedge pclk);
        bus_init <= 1'b0;
        @(posedge pclk);
        rd(8'h00, 32'h0B60);
        print_verdict;
    end
endmodule

/* File: ecl_mem_model.sv */
/*
 * Memory-side model: issues read and write cycles on command and keeps
 * the stored check bits of sixteen words, indexed by address bits 4..1.
 * Assumes the bench pulses go for one edge and then waits for busy to fall.
 */
`timescale 1ns/100ps
module ecl_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic wr,
    input wire logic [21:1] addr,
    input wire logic es,
    input wire logic em,
    output logic busy,
    output logic got_unc,
    output logic got_dis,
    output logic got_force,
    output logic [5:0] got_chk,
    output logic cyc_req,
    output logic cyc_write,
    output logic [21:1] cyc_addr,
    output logic [5:0] cyc_check_rd,
    output logic [5:0] cyc_syndrome,
    output logic cyc_err_single,
    output logic cyc_err_multi,
    input wire logic cyc_done,
    input wire logic cyc_check_force,
    input wire logic [5:0] cyc_check_wr,
    input wire logic cyc_correct_dis,
    input wire logic cyc_uncorrectable
);
    logic [5:0] chk_mem [0:15];

    // ==========================================================
    // Cycle issue and answer capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) chk_mem[i] <= {2'b10, 4'(i)};
            {cyc_req, cyc_write, cyc_err_single, cyc_err_multi, busy} <= '0;
            {got_unc, got_dis, got_force, got_chk} <= '0;
            cyc_addr <= '0;
            cyc_check_rd <= '0;
            cyc_syndrome <= '0;
        end else begin
            cyc_req <= 1'b0;
            if (go && !busy) begin
                cyc_req <= 1'b1;
                cyc_write <= wr;
                cyc_addr <= addr;
                cyc_check_rd <= chk_mem[addr[4:1]];
                cyc_syndrome <= addr[6:1] ^ 6'h2A;
                cyc_err_single <= es;
                cyc_err_multi <= em;
                busy <= 1'b1;
            end else if (cyc_done) begin
                busy <= 1'b0;
                {got_unc, got_dis, got_force, got_chk} <=
                    {cyc_uncorrectable, cyc_correct_dis, cyc_check_force, cyc_check_wr};
                if (cyc_check_force && cyc_write) chk_mem[cyc_addr[4:1]] <= cyc_check_wr;
            end else if (!cyc_req) begin
                cyc_check_rd <= ~cyc_check_rd;
                {cyc_err_single, cyc_err_multi} <= 2'b00;
            end
        end
    end
endmodule

/* File: ecl_mode_decode.sv */
/*
 * Operating mode decode and block protection for one memory cycle.
 * Assumes word address bits 21..1 of the current cycle at the input.
 */
`timescale 1ns/100ps
module ecl_mode_decode (
    input wire logic dis,
    input wire logic diag,
    input wire logic pen,
    input wire logic bsel,
    input wire logic [ecl_pkg::MEM_A_MSB:1] addr,
    output ecl_pkg::ecl_mode_t mode,
    output logic in_prot,
    output logic eff_diag,
    output logic eff_dis
);
    // ==========================================================
    // Protected block hit
    // block select picks half
    wire in_first_32k = (addr[ecl_pkg::MEM_A_MSB:ecl_pkg::BLK_BIT + 1] == '0);
    assign in_prot = pen & in_first_32k & (addr[ecl_pkg::BLK_BIT] == bsel);
    assign eff_diag = diag & ~in_prot;
    assign eff_dis = dis & ~in_prot;

    // ==========================================================
    // seven modes
    always_comb begin
        case ({pen, diag, dis})
            3'h1: mode = ecl_pkg::ECL_NORM_DIS;
            3'h2: mode = ecl_pkg::ECL_DIAG_EN;
            3'h3: mode = ecl_pkg::ECL_DIAG_DIS;
            3'h5: mode = ecl_pkg::ECL_NORM_DIS_PROT;
            3'h6: mode = ecl_pkg::ECL_DIAG_EN_PROT;
            3'h7: mode = ecl_pkg::ECL_DIAG_DIS_PROT;
            default: mode = ecl_pkg::ECL_NORM_EN;
        endcase
    end
endmodule

/* File: ecl_pkg.sv */
/*
 * Shared constants and types of the error-log control block: register
 * offsets, control and status bit positions, reset values and modes.
 * Assumes a 32-bit APB register bus and 16-bit control/status word.
 */
package ecl_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CSR = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;

    // ==========================================================
    // Control and status word layout
    localparam int CSR_W = 16;
    localparam int B_DIS = 1;
    localparam int B_DIAG = 2;
    localparam int B_BSEL = 3;
    localparam int B_SINGLE = 4;
    localparam int B_MF_LO = 5;
    localparam int B_CHK_HI = 10;
    localparam int B_MF_HI = 11;
    localparam int B_RSVD = 12;
    localparam int B_PEN = 13;
    localparam int B_HSEL = 14;
    localparam int B_UNC = 15;
    localparam int CHK_W = 6;
    localparam int LO_W = 7;
    localparam int HI_W = 5;
    localparam logic [15:0] CTL_MASK = 16'hE01E;
    localparam logic [15:0] CSR_RESET = 16'h0000;

    // ==========================================================
    // Memory address: word address bits 21..1, protected block size 16K words
    localparam int MEM_A_MSB = 21;
    localparam int BLK_BIT = 15;

    // ==========================================================
    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_UNC = 0;
    localparam int IRQ_SINGLE = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    typedef enum logic [2:0] {
        ECL_NORM_EN,
        ECL_NORM_DIS,
        ECL_NORM_DIS_PROT,
        ECL_DIAG_EN,
        ECL_DIAG_DIS,
        ECL_DIAG_EN_PROT,
        ECL_DIAG_DIS_PROT
    } ecl_mode_t;

endpackage

/* File: ecl_reg_if.sv */
/*
 * Register access carrier between the APB slave and the register file.
 * Assumes one clock domain; the slave drives strobes, the file answers.
 */
`timescale 1ns/100ps
interface ecl_reg_if #(parameter int AW = 8);
    logic wr_en;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic hit;
    modport bus (output wr_en, output addr, output wdata, input rdata, input hit);
    modport regs (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface
